//--- two_cell_protect_sequencer.v
// digital control core of a two-cell lithium-ion protection device
`timescale 1ns/10ps
`include "protect_defs.vh"
module two_cell_protect_sequencer (
  // clock and reset
  input  wire i_sys_clk,
  input  wire i_resetn,
  // cell comparators, per cell (upper cell, lower cell below mid_cell_tap)
  input  wire i_upper_over_det,
  input  wire i_lower_over_det,
  input  wire i_upper_over_rel,
  input  wire i_lower_over_rel,
  input  wire i_upper_under_det,
  input  wire i_lower_under_det,
  // charger_minus_sense comparators
  input  wire i_sense_ocp,
  input  wire i_sense_scp,
  input  wire i_sense_stby_ret,
  input  wire i_sense_load,
  input  wire i_sense_charger,
  input  wire i_zero_volt_ok,
  input  wire i_cells_zero,
  // test strap
  input  wire i_quick_delay_pin,
  // gate and resistor controls
  output reg  o_charge_gate_out,
  output reg  o_discharge_gate_out,
  output reg  o_pullup_200k,
  output reg  o_pulldown_1m,
  output reg  o_pulldown_30k,
  output reg  o_standby,
  output reg  o_ovc_hyst_cancel
);

  ////////////////////////////////////////////////////////////////////////////
  // input registers: nothing downstream sees an unclocked comparator

  reg [12:0] in_q;
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      in_q <= 13'h0000;
    end else begin
      in_q <= {i_upper_over_det, i_lower_over_det, i_upper_over_rel, i_lower_over_rel,
               i_upper_under_det, i_lower_under_det, i_sense_ocp, i_sense_scp,
               i_sense_stby_ret, i_sense_load, i_sense_charger, i_zero_volt_ok,
               i_cells_zero};
    end
  end

  reg quick_q;
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      quick_q <= 1'b0;
    end else begin
      quick_q <= i_quick_delay_pin;
    end
  end

  wire any_over   = in_q[12] | in_q[11];
  wire both_rel   = in_q[10] & in_q[9];
  wire any_under  = in_q[8] | in_q[7];
  wire ocp        = in_q[6];
  wire scp        = in_q[5];
  wire stby_ret   = in_q[4];
  wire load_on    = in_q[3];
  wire charger_on = in_q[2];
  wire zv_ok      = in_q[1];
  wire cells_zero = in_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // delay lengths; quick mode divides every counted delay except the short delay

  function [`CNT_W-1:0] dly;
    input [`CNT_W-1:0] full;
    input              quick;
    begin
      if (quick) begin
        dly = full >> `QUICK_SHIFT;
      end else begin
        dly = full;
      end
    end
  endfunction

  localparam [`CNT_W-1:0] L_OVC_DET = `OVC_DET_CYC;
  localparam [`CNT_W-1:0] L_OVC_REL = `OVC_REL_CYC;
  localparam [`CNT_W-1:0] L_OVD_DET = `OVD_DET_CYC;
  localparam [`CNT_W-1:0] L_OVD_REL = `OVD_REL_CYC;
  localparam [`CNT_W-1:0] L_OCP_DET = `OCP_DET_CYC;
  localparam [`CNT_W-1:0] L_OCP_REL = `OCP_REL_CYC;
  localparam [`CNT_W-1:0] L_SCP_DET = `SCP_DET_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // fault state

  reg ovc_q;
  reg ovd_q;
  reg ocp_q;
  reg scp_q;
  reg stby_q;
  reg ovc_first_q;

  // hysteresis cancel: with load after detection, release at the detect level
  wire ovc_rel_cond = ovc_q & ((charger_on & both_rel) | (load_on & ~any_over));

  wire ovc_det_cond = ~ovc_q & any_over;
  wire ovd_det_cond = ~ovd_q & ~stby_q & any_under & ~ovc_det_cond;
  wire ovd_rel_cond = ovd_q & ~stby_q & ~any_under;
  wire ocp_det_cond = ~ocp_q & ~scp_q & ocp & ~ovc_q & ~ovd_q;
  wire scp_det_cond = ~scp_q & scp;
  wire ocp_rel_cond = (ocp_q | scp_q) & ~ocp;

  wire [6:0] cond = {ovc_det_cond, ovc_rel_cond, ovd_det_cond, ovd_rel_cond,
                     ocp_det_cond, scp_det_cond, ocp_rel_cond};
  wire [6:0] done;
  wire [`CNT_W*7-1:0] lens = {dly(L_OVC_DET, quick_q), dly(L_OVC_REL, quick_q),
                              dly(L_OVD_DET, quick_q), dly(L_OVD_REL, quick_q),
                              dly(L_OCP_DET, quick_q), L_SCP_DET, dly(L_OCP_REL, quick_q)};

  // short delay is counter-timed like the rest, but quick mode leaves it alone
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_tmr
      persist_timer u_tmr (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_cond    (cond[g]),
        .i_len     (lens[`CNT_W*g +: `CNT_W]),
        .o_done    (done[g])
      );
    end
  endgenerate

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ovc_q       <= 1'b0;
      ovd_q       <= 1'b0;
      ocp_q       <= 1'b0;
      scp_q       <= 1'b0;
      stby_q      <= 1'b0;
      ovc_first_q <= 1'b0;
    end else begin
      if (done[6]) begin
        ovc_q       <= 1'b1;
        ovc_first_q <= ~ovd_q;
      end else if (done[5]) begin
        ovc_q       <= 1'b0;
        ovc_first_q <= 1'b0;
      end
      if (done[4]) begin
        ovd_q  <= 1'b1;
        stby_q <= ~ovc_q;
        ocp_q  <= 1'b0;
      end else if (stby_q && stby_ret) begin
        stby_q <= 1'b0;
      end else if (done[3]) begin
        ovd_q <= 1'b0;
      end
      if (done[1]) begin
        scp_q <= 1'b1;
      end else if (done[2]) begin
        ocp_q <= 1'b1;
      end else if (done[0]) begin
        ocp_q <= 1'b0;
        scp_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_charge_gate_out    <= 1'b1;
      o_discharge_gate_out <= 1'b1;
      o_pullup_200k        <= 1'b0;
      o_pulldown_1m        <= 1'b0;
      o_pulldown_30k       <= 1'b0;
      o_standby            <= 1'b0;
      o_ovc_hyst_cancel    <= 1'b0;
    end else begin
      // a zero-volt pack has no valid cell compare, so the supply test decides
      if (cells_zero) begin
        o_charge_gate_out <= zv_ok;
      end else begin
        o_charge_gate_out <= ~ovc_q;
      end
      o_discharge_gate_out <= ~(ovd_q | ocp_q | scp_q);
      o_pullup_200k        <= ovd_q;
      o_pulldown_30k       <= scp_q & ~ovd_q;
      o_pulldown_1m        <= ocp_q & ~scp_q & ~ovd_q & ~ovc_first_q;
      o_standby            <= stby_q;
      o_ovc_hyst_cancel    <= ovc_q & load_on;
    end
  end

endmodule

//--- protect_defs.vh
// timing counts for the two-cell protection sequencer
`ifndef PROTECT_DEFS_VH
`define PROTECT_DEFS_VH
`define CLK_HZ              50000000
`define OVC_DET_US          1000000
`define OVC_REL_US          40000
`define OVD_DET_US          100000
`define OVD_REL_US          1000
`define OCP_DET_US          5000
`define OCP_REL_US          1000
`define SCP_DET_US          500
`define CYC_PER_US          (`CLK_HZ / 1000000)
`define OVC_DET_CYC         (`OVC_DET_US * `CYC_PER_US)
`define OVC_REL_CYC         (`OVC_REL_US * `CYC_PER_US)
`define OVD_DET_CYC         (`OVD_DET_US * `CYC_PER_US)
`define OVD_REL_CYC         (`OVD_REL_US * `CYC_PER_US)
`define OCP_DET_CYC         (`OCP_DET_US * `CYC_PER_US)
`define OCP_REL_CYC         (`OCP_REL_US * `CYC_PER_US)
`define SCP_DET_CYC         (`SCP_DET_US * `CYC_PER_US)
`define QUICK_SHIFT         6
`define CNT_W               26
`endif

//--- persist_timer.v
// persistence timer: flags done once its condition has held for the whole load count
`timescale 1ns/10ps
`include "protect_defs.vh"
module persist_timer (
  // clock and reset
  input  wire                i_sys_clk,
  input  wire                i_resetn,
  // condition and length
  input  wire                i_cond,
  input  wire [`CNT_W-1:0]   i_len,
  // result
  output wire                o_done
);
  reg [`CNT_W-1:0] cnt_q;

  assign o_done = i_cond && (cnt_q >= i_len);

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= {`CNT_W{1'b0}};
    end else if (!i_cond) begin
      cnt_q <= {`CNT_W{1'b0}};
    end else if (cnt_q < i_len) begin
      cnt_q <= cnt_q + {{(`CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule

//--- fet_load_model.sv
// load and power fet model that sets the sense node comparator levels
`timescale 1ns/10ps
module fet_load_model (
  // gate and resistor state from the block
  input  wire logic i_dis_gate,
  input  wire logic i_pd_on,
  // load request from the bench
  input  wire logic i_overload,
  input  wire logic i_short,
  // sense node comparators
  output wire logic o_ocp,
  output wire logic o_scp
);
  // node stays high while the fet conducts or no resistor pulls it down
  wire hold = i_dis_gate || !i_pd_on;
  assign o_ocp = (i_overload || i_short) && hold;
  assign o_scp = i_short && hold;
endmodule

//--- two_cell_protect_sequencer_properties.sv
// port assertions for the protection sequencer
`timescale 1ns/10ps
module protect_props (
  input wire logic i_sys_clk, i_resetn, i_sense_ocp, i_sense_scp,
  input wire logic i_upper_under_det, i_lower_under_det, i_cells_zero, i_zero_volt_ok,
  input wire logic o_charge_gate_out, o_discharge_gate_out, o_pullup_200k,
  input wire logic o_pulldown_1m, o_pulldown_30k, o_standby, o_ovc_hyst_cancel
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // saturating run length of the short comparator
  logic [15:0] scp_run_q;
  wire fault = i_sense_ocp || i_sense_scp || i_upper_under_det || i_lower_under_det;
  always_ff @(posedge i_sys_clk or negedge i_resetn)
    if (!i_resetn) scp_run_q <= 16'h0000;
    else if (!i_sense_scp) scp_run_q <= 16'h0000;
    else if (scp_run_q != 16'hFFFF) scp_run_q <= scp_run_q + 16'h0001;
  pull_excl_a: assert property (
    !(o_pullup_200k && (o_pulldown_1m || o_pulldown_30k))) else $error("pull up and down together");
  stby_pull_a: assert property (o_standby |-> o_pullup_200k)
    else $error("standby without pull-up");
  dis_cause_a: assert property ($fell(o_discharge_gate_out) |-> $past(fault, 4))
    else $error("discharge gate fell without fault");
  short_time_a: assert property ($rose(o_pulldown_30k) |-> scp_run_q >= 16'h61A8)
    else $error("short declared too early");
  dis_ret_a: assert property ($rose(o_discharge_gate_out) |-> !$past(i_sense_ocp || i_sense_scp, 4))
    else $error("discharge gate rose under fault");
  zero_volt_a: assert property ((i_cells_zero && i_zero_volt_ok)[*4] |-> o_charge_gate_out)
    else $error("zero volt charge blocked");
  hyst_gate_a: assert property (o_ovc_hyst_cancel |-> !o_charge_gate_out)
    else $error("hysteresis cancel outside over-charge");
  short_dis_a: assert property ($rose(o_pulldown_30k) |-> !o_discharge_gate_out && !o_standby)
    else $error("short state wrong");
  ocp_dis_a: assert property ($rose(o_pulldown_1m) |-> !o_discharge_gate_out && !o_standby)
    else $error("over-current state wrong");
  cover property ($rose(o_pulldown_30k));
  cover property ($rose(o_pulldown_1m));
  cover property ($rose(o_discharge_gate_out));
endmodule
bind two_cell_protect_sequencer protect_props protect_props_i (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_sense_ocp(i_sense_ocp), .i_sense_scp(i_sense_scp),
  .i_upper_under_det(i_upper_under_det), .i_lower_under_det(i_lower_under_det),
  .i_cells_zero(i_cells_zero), .i_zero_volt_ok(i_zero_volt_ok), .o_charge_gate_out(o_charge_gate_out),
  .o_discharge_gate_out(o_discharge_gate_out), .o_pullup_200k(o_pullup_200k), .o_pulldown_1m(o_pulldown_1m),
  .o_pulldown_30k(o_pulldown_30k), .o_standby(o_standby), .o_ovc_hyst_cancel(o_ovc_hyst_cancel));

//--- tb_top.sv
// self-checking bench for the protection sequencer
`timescale 1ns/10ps
module tb_top;
  logic       i_sys_clk, i_resetn, cells_zero, zero_ok, quick, overload, short_req;
  logic [8:0] misc;
  wire        ocp, scp, chg, dis, pu, pd1m, pd30k, stby;
  int         fail_count, checks_done;
  two_cell_protect_sequencer two_cell_protect_sequencer_i (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_upper_over_det(misc[0]), .i_lower_over_det(misc[1]),
    .i_upper_over_rel(misc[2]), .i_lower_over_rel(misc[3]), .i_upper_under_det(misc[4]),
    .i_lower_under_det(misc[5]), .i_sense_ocp(ocp), .i_sense_scp(scp), .i_sense_stby_ret(misc[6]),
    .i_sense_load(misc[7]), .i_sense_charger(misc[8]), .i_zero_volt_ok(zero_ok), .i_cells_zero(cells_zero),
    .i_quick_delay_pin(quick), .o_charge_gate_out(chg), .o_discharge_gate_out(dis), .o_pullup_200k(pu),
    .o_pulldown_1m(pd1m), .o_pulldown_30k(pd30k), .o_standby(stby), .o_ovc_hyst_cancel());
  fet_load_model fet_load_model_i (.i_dis_gate(dis), .i_pd_on(pd1m || pd30k), .i_overload(overload),
    .i_short(short_req), .o_ocp(ocp), .o_scp(scp));
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic check(input string name, input logic exp, input logic seen);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic wait_dis(input logic lv, input int lim);
    for (int n = 0; n < lim && dis !== lv; n++) cyc(1);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // short delay is counted, but its length ignores the quick strap
  // normal strap here: a quick over-current count would otherwise trip long before the short does
  task automatic t_short;
    quick = 1'b0;
    short_req = 1'b1;
    cyc(24990);
    check("dis_early", 1'b1, dis);
    wait_dis(1'b0, 20);
    quick = 1'b1;
    short_req = 1'b0;
    check("dis_short", 1'b0, dis);
    check("pd30k", 1'b1, pd30k);
    cyc(770);
    check("dis_ret_early", 1'b0, dis);
    wait_dis(1'b1, 40);
    check("dis_ret", 1'b1, dis);
  endtask
  // a dropout mid-count must restart the quick over-current delay
  task automatic t_ocp;
    overload = 1'b1;
    cyc(2000);
    overload = 1'b0;
    cyc(3);
    overload = 1'b1;
    cyc(3895);
    check("dis_restart", 1'b1, dis);
    wait_dis(1'b0, 30);
    check("dis_ocp", 1'b0, dis);
    check("pd1m", 1'b1, pd1m);
    check("stby_ocp", 1'b0, stby);
    overload = 1'b0;
    wait_dis(1'b1, 830);
    check("dis_ocp_ret", 1'b1, dis);
  endtask
  task automatic t_zero;
    cells_zero = 1'b1;
    cyc(8);
    check("chg_zero_off", 1'b0, chg);
    zero_ok = 1'b1;
    cyc(8);
    check("chg_zero_on", 1'b1, chg);
  endtask
  initial begin
    {i_resetn, cells_zero, zero_ok, overload, short_req, misc} = 14'h0000;
    {quick, fail_count, checks_done} = 0;
    cyc(2);
    i_resetn = 1'b1;
    cyc(1);
    check("chg_rst", 1'b1, chg);
    check("pu_rst", 1'b0, pu);
    quick = 1'b1;
    t_short();
    t_ocp();
    t_zero();
    conclude();
  end
  initial begin
    repeat (60000) @(posedge i_sys_clk);
    fail_count++;
    conclude();
  end
endmodule
